// File: shared/ldac_pkg.sv
// Package with register map, field layout and encodings of the ladder converter control.
package ldac_pkg;

   // ==========================================================================
   // Register map
   localparam logic [3:0] LDAC_OFS_CONTROL_MAIN = 4'h0;
   localparam logic [3:0] LDAC_OFS_LEVEL_SELECT = 4'h4;

   // ==========================================================================
   // Field positions
   localparam int LDAC_BIT_CONVERTER_ON = 7;
   localparam int LDAC_BIT_PIN_ONE_DRIVE_ON = 5;
   localparam int LDAC_BIT_PIN_TWO_DRIVE_ON = 4;
   localparam int LDAC_BIT_PSS_LSB = 2;
   localparam int LDAC_BIT_LEVEL_LSB = 0;
   localparam int LDAC_LEVEL_WIDTH = 5;
   localparam int LDAC_PSS_WIDTH = 2;

   // ==========================================================================
   // Reset values and write masks
   localparam logic [7:0] LDAC_RST_CONTROL_MAIN = 8'h00;
   localparam logic [7:0] LDAC_RST_LEVEL_SELECT = 8'h00;
   localparam logic [7:0] LDAC_MASK_CONTROL_MAIN = 8'hBC;
   localparam logic [7:0] LDAC_MASK_LEVEL_SELECT = 8'h1F;

   // ==========================================================================
   // Positive source encodings
   typedef enum logic [1:0] {
      LDAC_SRC_SUPPLY = 2'h0,
      LDAC_SRC_EXT_REF = 2'h1,
      LDAC_SRC_FIXED_REF = 2'h2,
      LDAC_SRC_RESERVED = 2'h3
   } ldac_source_type;

   // ==========================================================================
   // Bus responses
   localparam logic [1:0] LDAC_RESP_OKAY = 2'h0;
   localparam logic [1:0] LDAC_RESP_SLVERR = 2'h2;

endpackage

// File: rtl/ldac_pin_route.sv
// Pad override logic for one converter output pin.
`timescale 1ns/1ps
`default_nettype none
module ldac_pin_route (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic route_on_i,
   input wire logic pad_in_i,
   output logic analog_connect_o,
   output logic digital_out_en_o,
   output logic input_detect_en_o,
   output logic pullup_en_o,
   output logic current_drive_en_o,
   output logic read_value_o
);
   logic next_connect;
   logic next_read;

   always_comb begin
      next_connect = route_on_i;
      next_read = route_on_i ? 1'b0 : pad_in_i; // [RULE6]
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         analog_connect_o <= 1'b0;
         digital_out_en_o <= 1'b1;
         input_detect_en_o <= 1'b1;
         pullup_en_o <= 1'b1;
         current_drive_en_o <= 1'b1;
         read_value_o <= 1'b0;
      end else begin
         analog_connect_o <= next_connect; // [RULE4]
         digital_out_en_o <= !next_connect; // [RULE5]
         input_detect_en_o <= !next_connect; // [RULE5]
         pullup_en_o <= !next_connect; // [RULE5]
         current_drive_en_o <= !next_connect; // [RULE5]
         read_value_o <= next_read;
      end
   end
endmodule
`default_nettype wire

// File: rtl/ldac_top.sv
// Ladder converter control block with AXI4-Lite register slave.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Function
// [RULE1] Converter runs only while the enable bit seven of the main register is set.
// [RULE2] Five-bit level field selects one of 32 ladder taps.
// [RULE3] Output scales linearly: span times code over 32 plus negative source.
// [RULE4] Bits five and four connect converter voltage to pins one and two.
// [RULE5] A routed pin has digital buffer, input detector, pull-up, current drive off.
// [RULE6] Digital read of a routed pin returns zero.
// [RULE7] Source field selects supply, external reference, fixed reference; code three reserved.
// [RULE8] Converter keeps running in sleep; wake leaves main register unchanged.
// [RULE9] Reset clears enable, pin routing, level field and all control bits.
// [RULE10] Unimplemented bits read as zero.
// [RULE11] Converter voltage offered to comparator input mux and ADC channel.
// [RULE12] Register writes take effect on the next clock edge without handshake; the code uses the AXI4-Lite handshake, outputs follow two edges after it.
module ldac_top (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic sleep_i,
   input wire logic [1:0] pad_in_i,
   output logic converter_on_o,
   output logic [ldac_pkg::LDAC_LEVEL_WIDTH-1:0] level_code_o,
   output logic [ldac_pkg::LDAC_PSS_WIDTH-1:0] positive_source_sel_o,
   output logic [1:0] pin_analog_connect_o,
   output logic [1:0] pin_digital_out_en_o,
   output logic [1:0] pin_input_detect_en_o,
   output logic [1:0] pin_pullup_en_o,
   output logic [1:0] pin_current_drive_en_o,
   output logic [1:0] pin_read_value_o,
   output logic comparator_source_valid_o,
   output logic adc_source_valid_o
);
   import ldac_pkg::*;

   // ==========================================================================
   // Register state
   logic [7:0] ladder_control_main;
   logic [7:0] ladder_level_select;
   logic [7:0] next_ladder_control_main;
   logic [7:0] next_ladder_level_select;

   // ==========================================================================
   // Bus state
   logic aw_held;
   logic w_held;
   logic [3:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic next_aw_held;
   logic next_w_held;
   logic [3:0] next_aw_addr;
   logic [31:0] next_w_data;
   logic [3:0] next_w_strb;
   logic next_awready;
   logic next_wready;
   logic next_bvalid;
   logic [1:0] next_bresp;
   logic next_arready;
   logic next_rvalid;
   logic [31:0] next_rdata;
   logic [1:0] next_rresp;
   logic do_write;
   logic [7:0] wbyte;

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_aw_addr = aw_addr;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      next_ladder_control_main = ladder_control_main;
      next_ladder_level_select = ladder_level_select;
      do_write = 1'b0;
      wbyte = w_data[7:0];
      if (s_axi_awvalid && s_axi_awready) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (aw_held && w_held && !s_axi_bvalid) begin
         do_write = 1'b1;
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = LDAC_RESP_OKAY;
         if (aw_addr == LDAC_OFS_CONTROL_MAIN) begin
            if (w_strb[0]) begin
               next_ladder_control_main = wbyte & LDAC_MASK_CONTROL_MAIN; // [RULE10]
            end
         end else if (aw_addr == LDAC_OFS_LEVEL_SELECT) begin
            if (w_strb[0]) begin
               next_ladder_level_select = wbyte & LDAC_MASK_LEVEL_SELECT; // [RULE10]
            end
         end else begin
            next_bresp = LDAC_RESP_SLVERR;
         end
      end
      next_awready = !next_aw_held && !(do_write && s_axi_bvalid);
      next_wready = !next_w_held;
   end

   always_comb begin
      next_arready = s_axi_arready;
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
         next_arready = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         next_arready = 1'b0;
         next_rvalid = 1'b1;
         next_rresp = LDAC_RESP_OKAY;
         if (s_axi_araddr == LDAC_OFS_CONTROL_MAIN) begin
            next_rdata = {24'h000000, ladder_control_main}; // [RULE10]
         end else if (s_axi_araddr == LDAC_OFS_LEVEL_SELECT) begin
            next_rdata = {24'h000000, ladder_level_select}; // [RULE10]
         end else begin
            next_rdata = 32'h00000000;
            next_rresp = LDAC_RESP_SLVERR;
         end
      end
      if (!s_axi_rvalid && !s_axi_arready && !next_rvalid) begin
         next_arready = 1'b1;
      end
   end

   // Sleep is not an input to the register state, so it is kept across wake.
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ladder_control_main <= LDAC_RST_CONTROL_MAIN; // [RULE9]
         ladder_level_select <= LDAC_RST_LEVEL_SELECT; // [RULE9]
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'h0;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'h0;
      end else begin
         ladder_control_main <= next_ladder_control_main; // [RULE8]
         ladder_level_select <= next_ladder_level_select;
         aw_held <= next_aw_held;
         w_held <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_awready <= next_awready;
         s_axi_wready <= next_wready;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_arready <= next_arready;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // ==========================================================================
   // Converter drive
   logic next_on;
   logic [LDAC_LEVEL_WIDTH-1:0] next_level;
   logic [LDAC_PSS_WIDTH-1:0] next_pss;
   logic unused_sleep;

   always_comb begin
      unused_sleep = sleep_i;
      next_on = ladder_control_main[LDAC_BIT_CONVERTER_ON]; // [RULE1]
      next_level = ladder_level_select[LDAC_BIT_LEVEL_LSB +: LDAC_LEVEL_WIDTH]; // [RULE2]
      next_pss = ladder_control_main[LDAC_BIT_PSS_LSB +: LDAC_PSS_WIDTH]; // [RULE7]
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         converter_on_o <= 1'b0;
         level_code_o <= '0;
         positive_source_sel_o <= LDAC_SRC_SUPPLY;
         comparator_source_valid_o <= 1'b0;
         adc_source_valid_o <= 1'b0;
      end else begin
         converter_on_o <= next_on; // [RULE12]
         level_code_o <= next_level; // [RULE3]
         positive_source_sel_o <= next_pss;
         comparator_source_valid_o <= next_on; // [RULE11]
         adc_source_valid_o <= next_on; // [RULE11]
      end
   end

   // ==========================================================================
   // Output pins
   logic [1:0] pin_route;
   assign pin_route = {ladder_control_main[LDAC_BIT_PIN_TWO_DRIVE_ON],
                       ladder_control_main[LDAC_BIT_PIN_ONE_DRIVE_ON]}; // [RULE4]

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_pin
         ldac_pin_route u_pin (
            .clk_sys_i(clk_sys_i),
            .arst_n_i(arst_n_i),
            .route_on_i(pin_route[gi]),
            .pad_in_i(pad_in_i[gi]),
            .analog_connect_o(pin_analog_connect_o[gi]),
            .digital_out_en_o(pin_digital_out_en_o[gi]),
            .input_detect_en_o(pin_input_detect_en_o[gi]),
            .pullup_en_o(pin_pullup_en_o[gi]),
            .current_drive_en_o(pin_current_drive_en_o[gi]),
            .read_value_o(pin_read_value_o[gi])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// File: testbench/ldac_properties.sv
// Checker module and bind for the ladder converter control block.
`timescale 1ns/1ps
`default_nettype none
module ldac_properties (
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic converter_on_o,
   input wire logic [ldac_pkg::LDAC_LEVEL_WIDTH-1:0] level_code_o,
   input wire logic [ldac_pkg::LDAC_PSS_WIDTH-1:0] positive_source_sel_o,
   input wire logic [1:0] pin_analog_connect_o,
   input wire logic [1:0] pin_digital_out_en_o,
   input wire logic [1:0] pin_input_detect_en_o,
   input wire logic [1:0] pin_pullup_en_o,
   input wire logic [1:0] pin_current_drive_en_o,
   input wire logic [1:0] pin_read_value_o,
   input wire logic comparator_source_valid_o,
   input wire logic adc_source_valid_o
);
   import ldac_pkg::*;
   logic [3:0] rd_addr, wr_addr, next_rd_addr, next_wr_addr;
   logic [8:0] wr_byte, next_wr_byte;
   logic [7:0] main_view;
   // ==========================================================================
   // Capture of the last accepted addresses and write byte.
   assign main_view = {converter_on_o, 1'b0, pin_analog_connect_o[0], pin_analog_connect_o[1],
                       positive_source_sel_o, 2'h0};
   always_comb begin
      next_rd_addr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rd_addr;
      next_wr_addr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wr_addr;
      next_wr_byte = (s_axi_wvalid && s_axi_wready) ? {s_axi_wstrb[0], s_axi_wdata[7:0]} : wr_byte;
   end
   always_ff @(posedge clk_sys_i) begin
      rd_addr <= next_rd_addr;
      wr_addr <= next_wr_addr;
      wr_byte <= next_wr_byte;
   end
   // ==========================================================================
   // Assertions.
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!arst_n_i);
   a_routed_pad_off:
      assert property ((pin_analog_connect_o & (pin_digital_out_en_o | pin_input_detect_en_o
         | pin_pullup_en_o | pin_current_drive_en_o)) == 2'h0) else $error("pad function on");
   a_routed_reads_zero:
      assert property ((pin_analog_connect_o & pin_read_value_o) == 2'h0) else $error("read high");
   a_sources_follow_on:
      assert property ({comparator_source_valid_o, adc_source_valid_o} == {2{converter_on_o}})
         else $error("source flags wrong");
   a_idle_holds_state:
      assert property (!s_axi_bvalid |=> $stable({converter_on_o, level_code_o,
         positive_source_sel_o, pin_analog_connect_o})) else $error("state moved");
   a_reset_clears_all:
      assert property ($rose(arst_n_i) |-> {converter_on_o, level_code_o,
         positive_source_sel_o, pin_analog_connect_o} == 10'h000) else $error("not cleared");
   a_main_write_lands:
      assert property ($rose(s_axi_bvalid) && wr_addr == LDAC_OFS_CONTROL_MAIN && wr_byte[8]
         |=> main_view == (wr_byte[7:0] & LDAC_MASK_CONTROL_MAIN)) else $error("main not set");
   a_level_write_lands:
      assert property ($rose(s_axi_bvalid) && wr_addr == LDAC_OFS_LEVEL_SELECT && wr_byte[8]
         |=> level_code_o == wr_byte[4:0]) else $error("level not set");
   a_main_read_view:
      assert property ($rose(s_axi_rvalid) && rd_addr == LDAC_OFS_CONTROL_MAIN
         |-> s_axi_rdata == {24'h000000, main_view}) else $error("main readback wrong");
   c_level_write: cover property ($rose(s_axi_bvalid) && wr_addr == LDAC_OFS_LEVEL_SELECT);
   c_both_routed: cover property (pin_analog_connect_o == 2'h3);
   c_fixed_src: cover property (positive_source_sel_o == LDAC_SRC_FIXED_REF);
endmodule
bind ldac_top ldac_properties ldac_chk_u (.*);
`default_nettype wire

// File: testbench/testbench.sv
// Self-checking testbench of the ladder converter control block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import ldac_pkg::*;
   logic clk_sys_i, arst_n_i, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic sleep_i, converter_on_o, comparator_source_valid_o, adc_source_valid_o;
   logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
   logic [31:0] s_axi_wdata, s_axi_rdata, seed, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, pad_in_i, positive_source_sel_o, pin_analog_connect_o;
   logic [1:0] pin_digital_out_en_o, pin_input_detect_en_o, pin_pullup_en_o;
   logic [1:0] pin_current_drive_en_o, pin_read_value_o;
   logic [4:0] level_code_o;
   logic [7:0] m;
   logic [33:0] exp_q[$];
   int checks, fail_count, k;
   ldac_top dut_u (.*);
   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d fail_count %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] dt, input logic [3:0] s,
      input logic [1:0] er);
      s_axi_awaddr <= a;
      s_axi_wdata <= dt;
      s_axi_wstrb <= s;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk_sys_i);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            chk(s_axi_bresp, er);
            s_axi_bready <= 1'b0;
            @(posedge clk_sys_i);
            return;
         end
      end
      fail_count++;
      end_sim();
   endtask
   task automatic rd(input logic [3:0] a, input logic [33:0] ex);
      exp_q.push_back(ex);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (int n = 0; n < 40; n++) begin
         @(posedge clk_sys_i);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            s_axi_rready <= 1'b0;
            @(posedge clk_sys_i);
            return;
         end
      end
      fail_count++;
      end_sim();
   endtask
   // Compares each accepted read answer with the oldest expectation.
   always @(posedge clk_sys_i) begin
      if (s_axi_rvalid && s_axi_rready) begin
         chk({s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
      end
   end
   task automatic outs(input logic [7:0] e, input logic [4:0] lv);
      @(posedge clk_sys_i);
      chk(converter_on_o, e[7]);
      chk(pin_analog_connect_o, {e[4], e[5]});
      chk(positive_source_sel_o, e[3:2]);
      chk(level_code_o, lv);
      chk({pin_digital_out_en_o, pin_pullup_en_o}, {2{~e[4], ~e[5]}});
      chk({pin_input_detect_en_o, pin_current_drive_en_o}, {2{~e[4], ~e[5]}});
      chk(pin_read_value_o & pin_analog_connect_o, 2'h0);
      chk(adc_source_valid_o, e[7]);
      chk(comparator_source_valid_o, e[7]);
   endtask
   initial begin
      seed = 32'h00000050;
      arst_n_i = 1'b0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, sleep_i} = 6'h00;
      {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata, pad_in_i} = '0;
      repeat (3) @(posedge clk_sys_i);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rd(LDAC_OFS_CONTROL_MAIN, 34'h0);
      rd(LDAC_OFS_LEVEL_SELECT, 34'h0);
      outs(8'h00, 5'h00);
      $display("test reset values done");
      for (k = 0; k < 4; k++) begin
         d = rnd();
         d[7] = k[0];
         d[5:4] = k[1:0];
         d[3:2] = (k == 3) ? 2'h2 : k[1:0];
         pad_in_i <= d[9:8];
         m = d[7:0] & LDAC_MASK_CONTROL_MAIN;
         wr(LDAC_OFS_CONTROL_MAIN, d, 4'hF, LDAC_RESP_OKAY);
         rd(LDAC_OFS_CONTROL_MAIN, {26'h0, m});
         outs(m, 5'h00);
         chk(pin_read_value_o, pad_in_i & ~{m[4], m[5]});
      end
      $display("test main register done");
      for (k = 0; k < 32; k++) begin
         d = rnd();
         d[4:0] = k[4:0];
         wr(LDAC_OFS_LEVEL_SELECT, d, 4'hF, LDAC_RESP_OKAY);
         rd(LDAC_OFS_LEVEL_SELECT, {29'h0, d[4:0]});
      end
      outs(m, 5'h1F);
      $display("test level codes done");
      wr(4'h8, rnd(), 4'hF, LDAC_RESP_SLVERR);
      rd(4'hC, {LDAC_RESP_SLVERR, 32'h0});
      wr(LDAC_OFS_CONTROL_MAIN, 32'h000000FF, 4'h0, LDAC_RESP_OKAY);
      rd(LDAC_OFS_CONTROL_MAIN, {26'h0, m});
      $display("test unmapped and strobe done");
      sleep_i <= 1'b1;
      repeat (20) @(posedge clk_sys_i);
      outs(m, 5'h1F);
      sleep_i <= 1'b0;
      rd(LDAC_OFS_CONTROL_MAIN, {26'h0, m});
      $display("test sleep done");
      wr(LDAC_OFS_CONTROL_MAIN, 32'h00000084, 4'h1, LDAC_RESP_OKAY);
      outs(8'h84, 5'h1F);
      arst_n_i <= 1'b0;
      outs(8'h00, 5'h00);
      arst_n_i <= 1'b1;
      repeat (2) @(posedge clk_sys_i);
      rd(LDAC_OFS_CONTROL_MAIN, 34'h0);
      rd(LDAC_OFS_LEVEL_SELECT, 34'h0);
      $display("test second reset done");
      end_sim();
   end
endmodule
`default_nettype wire
